// ===== prs_pkg.sv
`default_nettype none
package prs_pkg;
	localparam int NSTG = 8;
	localparam int NGRP = 4;
	localparam int NSIG = 64;
	// clock and time base
	localparam int CLK_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES_DEF = MS_NS / CLK_NS;
	localparam int FORCE_MIN = 5;
	localparam int FORCE_MS_DEF = FORCE_MIN * 60 * 1000;
	// evaluation periods in ms
	localparam int PER_10_MS = 10;
	localparam int PER_20_MS = 20;
	localparam int PER_100_MS = 100;
	localparam logic [1:0] PER_SEL_10 = 2'h0;
	localparam logic [1:0] PER_SEL_20 = 2'h1;
	// register word indices (byte address = 4 * index)
	localparam logic [9:0] SET_WORDS = 10'h080;
	localparam logic [9:0] REG_CTRL_BASE = 10'h100;
	localparam logic [9:0] REG_STAT_BASE = 10'h108;
	localparam logic [9:0] REG_CNT_BASE = 10'h110;
	localparam logic [9:0] REG_FORCE = 10'h118;
	localparam logic [9:0] REG_IRQ_STAT = 10'h119;
	localparam logic [9:0] REG_IRQ_CLR = 10'h11A;
	localparam logic [9:0] REG_IRQ_EN = 10'h11B;
	// field positions
	localparam int F_NO_COMPARE_FLOOR_LSB = 16;
	localparam int F_HYST_LSB = 16;
	localparam int F_MODE_LSB = 24;
	localparam int F_SELB_LSB = 8;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_PER_LSB = 1;
	localparam int CTRL_GRP_LSB = 4;
	localparam int CTRL_ALT_LSB = 6;
	localparam int CTRL_SRC_LSB = 8;
	localparam int CTRL_IDX_LSB = 12;
	localparam int CTRL_FS_BIT = 16;
	localparam int CTRL_FT_BIT = 17;
	localparam int STAT_GRP_LSB = 4;
	localparam int CNT_TRIP_LSB = 16;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	// first of the five virtual analog inputs on the signal selector
	localparam logic [5:0] SIG_VAI_BASE = 6'h3B;
	typedef enum logic [1:0] {CMP_OVER, CMP_UNDER, CMP_DIFF, CMP_ABS} prs_mode_t;
	typedef enum logic [1:0] {SRC_NONE, SRC_DI, SRC_VI, SRC_IND} prs_src_t;
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_TRIP} prs_state_t;
	typedef struct packed {
		logic signed [15:0] pickup;
		logic signed [15:0] no_compare_floor;
		logic [15:0]        delay_ms;
		logic [6:0]         hyst;
		prs_mode_t          mode;
		logic [5:0]         sel_a;
		logic [5:0]         sel_b;
	} prs_set_t;
	typedef struct packed {
		logic blocked;
		logic start;
		logic trip;
	} prs_stat_t;
endpackage
`default_nettype wire

// ===== prs_stage.sv
`timescale 1ns/1ps
`default_nettype none
module prs_stage
(
	// clock and reset
	input  wire logic               clk_in,
	input  wire logic               sys_rst_in,
	// timing and control
	input  wire logic               ms_tick_in,
	input  wire logic               enable_in,
	input  wire logic [1:0]         period_in,
	input  wire logic               force_on_in,
	input  wire logic               force_start_in,
	input  wire logic               force_trip_in,
	// settings and operands
	input  wire prs_pkg::prs_set_t  cfg_in,
	input  wire logic signed [15:0] val_a_in,
	input  wire logic signed [15:0] val_b_in,
	// status
	output var prs_pkg::prs_stat_t  status_out,
	output var logic                start_pulse_out,
	output var logic                trip_pulse_out
);
	import prs_pkg::*;

	prs_state_t         st_q;
	prs_state_t         st_d;
	prs_stat_t          stat_d;
	logic [6:0]         per_q;
	logic [6:0]         per_lim;
	logic               eval;
	logic [15:0]        dly_q;
	logic signed [17:0] a;
	logic signed [17:0] b;
	logic signed [17:0] p;
	logic signed [17:0] flo;
	logic signed [17:0] dif;
	logic signed [17:0] x;
	logic signed [8:0]  h_lo;
	logic signed [8:0]  h_hi;
	logic signed [25:0] x100;
	logic signed [25:0] p100;
	logic signed [25:0] p_lo;
	logic signed [25:0] p_hi;
	logic               floor_ok;
	logic               pick;

	always_comb
	begin
		case (period_in)
			PER_SEL_10: per_lim = 7'(PER_10_MS);
			PER_SEL_20: per_lim = 7'(PER_20_MS);
			default: per_lim = 7'(PER_100_MS);
		endcase
	end
	// >= keeps the divider sane when the period is shortened mid-count
	assign eval = ms_tick_in && (per_q >= per_lim - 7'h01);

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			per_q <= 7'h00;
		else if (ms_tick_in)
			per_q <= eval ? 7'h00 : per_q + 7'h01;
	end

	assign a = 18'(val_a_in);
	assign b = 18'(val_b_in);
	assign p = 18'(cfg_in.pickup);
	assign flo = 18'(cfg_in.no_compare_floor);
	assign dif = a - b;

	always_comb
	begin
		case (cfg_in.mode)
			CMP_DIFF: x = dif;
			CMP_ABS: x = (dif < 0) ? -dif : dif;
			default: x = a;
		endcase
	end

	// dead band as percent of pick-up; scaled by 100 to avoid a divider
	assign h_lo = 9'sh064 - $signed({2'b00, cfg_in.hyst});
	assign h_hi = 9'sh064 + $signed({2'b00, cfg_in.hyst});
	assign x100 = 26'(x) * 26'sh064;
	assign p100 = 26'(p) * 26'sh064;
	assign p_lo = 26'(p) * 26'(h_lo);
	assign p_hi = 26'(p) * 26'(h_hi);
	assign floor_ok = a >= flo;

	always_comb
	begin
		if (cfg_in.mode == CMP_UNDER)
			pick = floor_ok && ((st_q != ST_IDLE) ? (x100 <= p_hi) : (x100 < p100));
		else
			pick = (st_q != ST_IDLE) ? (x100 >= p_lo) : (x100 > p100);
	end

	always_comb
	begin
		st_d = st_q;
		if (!enable_in)
			st_d = ST_IDLE;
		else if (eval && !pick)
			st_d = ST_IDLE;
		else if (eval && st_q == ST_IDLE)
			st_d = ST_START;
		else if (st_q == ST_START && dly_q >= cfg_in.delay_ms)
			st_d = ST_TRIP;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			st_q <= ST_IDLE;
		else
			st_q <= st_d;
	end

	// definite delay counts whole ms from the start, independent of fault size
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			dly_q <= 16'h0000;
		else if (st_d == ST_IDLE)
			dly_q <= 16'h0000;
		else if (st_q == ST_START && ms_tick_in)
			dly_q <= dly_q + 16'h0001;
	end

	always_comb
	begin
		stat_d.blocked = !enable_in;
		stat_d.start = (st_d != ST_IDLE) || (force_on_in && force_start_in && enable_in);
		stat_d.trip = (st_d == ST_TRIP) || (force_on_in && force_trip_in && enable_in);
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			status_out <= '{blocked: 1'b1, start: 1'b0, trip: 1'b0};
			start_pulse_out <= 1'b0;
			trip_pulse_out <= 1'b0;
		end
		else
		begin
			status_out <= stat_d;
			start_pulse_out <= stat_d.start & ~status_out.start;
			trip_pulse_out <= stat_d.trip & ~status_out.trip;
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	over_start_a: assert property (enable_in && eval && st_q == ST_IDLE && cfg_in.mode == CMP_OVER
		&& x100 > p100 |=> status_out.start)
		else $error("over mode did not start above pick-up");
	under_floor_a: assert property (enable_in && eval && cfg_in.mode == CMP_UNDER && a < flo
		&& !force_on_in |=> !status_out.start)
		else $error("under mode started below floor");
	trip_delay_a: assert property (st_q == ST_START && dly_q < cfg_in.delay_ms && !force_on_in
		|=> !status_out.trip)
		else $error("trip before operate delay");
	blocked_a: assert property (!enable_in |=> status_out.blocked && !status_out.start)
		else $error("disabled stage not blocked");
	force_trip_a: assert property (force_on_in && force_trip_in && enable_in |=> status_out.trip)
		else $error("forced trip not shown");
	hyst_hold_a: assert property (st_q != ST_IDLE && enable_in && eval && cfg_in.mode == CMP_OVER
		&& x100 >= p_lo |=> st_q != ST_IDLE)
		else $error("released inside dead band");
endmodule
`default_nettype wire

// ===== prs_top.sv
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - over starts above, under below limit.
// - first selector gives the supervised operand.
// - second selector only feeds difference modes.
// - under mode ignores values below floor.
// - trip after fixed definite operate delay.
// - pick-up scaled like the selected quantity.
// - many measured and five virtual analog inputs.
// - eight stages, each enabled or disabled.
// - four setting groups, switched by signal.
// - group source none, digital, virtual, indicator.
// - status blocked, start, trip; start and trip forceable in test.
// - test force flag clears after five minutes.
// - start and trip counters clearable.
module prs_top
#(
	parameter int MS_CYCLES = prs_pkg::MS_CYCLES_DEF,
	parameter int FORCE_MS = prs_pkg::FORCE_MS_DEF
)
(
	// clock and reset
	input  wire logic                                clk_in,
	input  wire logic                                sys_rst_in,
	// avalon-mm slave
	input  wire logic [11:0]                         avs_address_in,
	input  wire logic                                avs_read_in,
	input  wire logic                                avs_write_in,
	input  wire logic [31:0]                         avs_writedata_in,
	input  wire logic [3:0]                          avs_byteenable_in,
	output var logic [31:0]                          avs_readdata_out,
	output var logic                                 avs_waitrequest_out,
	// measurements and group select sources
	input  wire logic [prs_pkg::NSIG-1:0][15:0]      meas_in,
	input  wire logic [15:0]                         digital_input_n_in,
	input  wire logic [15:0]                         virtual_input_n_in,
	input  wire logic [15:0]                         indicator_signal_n_in,
	// to the output matrix
	output var logic [prs_pkg::NSTG-1:0]             stage_start_out,
	output var logic [prs_pkg::NSTG-1:0]             stage_trip_out,
	output var logic                                 irq_out
);
	import prs_pkg::*;

	logic [31:0]           set_mem_q [SET_WORDS];
	logic [31:0]           ctrl_q [NSTG];
	logic [1:0]            grp_q [NSTG];
	logic [15:0]           start_cnt_q [NSTG];
	logic [15:0]           trip_cnt_q [NSTG];
	logic [2*NSTG-1:0]     irq_stat_q;
	logic [2*NSTG-1:0]     irq_en_q;
	logic [17:0]           ms_cnt_q;
	logic                  ms_tick_q;
	logic                  force_q;
	logic [19:0]           force_cnt_q;
	logic                  wait_q;
	logic [31:0]           rd_d;
	logic                  req;
	logic                  wr_fire;
	logic [9:0]            widx;
	logic [NSTG-1:0]       src_on;
	logic [NSTG-1:0]       cnt_clr;
	logic [NSTG-1:0]       sp_w;
	logic [NSTG-1:0]       tp_w;
	prs_stat_t             stat_w [NSTG];

	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = new_v[8*i +: 8];
		return r;
	endfunction

	// one wait state on every access: read data are sampled in the first cycle, write data in the second
	assign req = avs_read_in | avs_write_in;
	assign wr_fire = avs_write_in & ~wait_q;
	assign widx = avs_address_in[11:2];

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			wait_q <= 1'b1;
		else
			wait_q <= ~(req & wait_q);
	end
	assign avs_waitrequest_out = wait_q;

	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (widx < SET_WORDS)
			rd_d = set_mem_q[widx[6:0]];
		else if (widx[9:3] == REG_CTRL_BASE[9:3])
			rd_d = ctrl_q[widx[2:0]];
		else if (widx[9:3] == REG_STAT_BASE[9:3])
		begin
			rd_d[2:0] = {stat_w[widx[2:0]].blocked, stat_w[widx[2:0]].start, stat_w[widx[2:0]].trip};
			rd_d[STAT_GRP_LSB +: 2] = grp_q[widx[2:0]];
		end
		else if (widx[9:3] == REG_CNT_BASE[9:3])
			rd_d = {trip_cnt_q[widx[2:0]], start_cnt_q[widx[2:0]]};
		else if (widx == REG_FORCE)
			rd_d[0] = force_q;
		else if (widx == REG_IRQ_STAT)
			rd_d[2*NSTG-1:0] = irq_stat_q;
		else if (widx == REG_IRQ_EN)
			rd_d[2*NSTG-1:0] = irq_en_q;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			avs_readdata_out <= REG_RST;
		else if (req & wait_q)
			avs_readdata_out <= rd_d;
	end

	// settings: stage, group and word index make up the word address
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			for (int i = 0; i < SET_WORDS; i++)
				set_mem_q[i] <= REG_RST;
		else if (wr_fire && widx < SET_WORDS)
			set_mem_q[widx[6:0]] <= be_merge(set_mem_q[widx[6:0]], avs_writedata_in, avs_byteenable_in);
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			for (int s = 0; s < NSTG; s++)
				ctrl_q[s] <= REG_RST;
		else if (wr_fire && widx[9:3] == REG_CTRL_BASE[9:3])
			ctrl_q[widx[2:0]] <= be_merge(ctrl_q[widx[2:0]], avs_writedata_in, avs_byteenable_in);
	end

	always_comb
	begin
		for (int s = 0; s < NSTG; s++)
		begin
			case (prs_src_t'(ctrl_q[s][CTRL_SRC_LSB +: 2]))
				SRC_DI: src_on[s] = digital_input_n_in[ctrl_q[s][CTRL_IDX_LSB +: 4]];
				SRC_VI: src_on[s] = virtual_input_n_in[ctrl_q[s][CTRL_IDX_LSB +: 4]];
				SRC_IND: src_on[s] = indicator_signal_n_in[ctrl_q[s][CTRL_IDX_LSB +: 4]];
				default: src_on[s] = 1'b0;
			endcase
			cnt_clr[s] = wr_fire && widx == REG_CNT_BASE + 10'(s);
		end
	end

	// an asserted source overrides the manual group with the alternate one
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			for (int s = 0; s < NSTG; s++)
				grp_q[s] <= 2'h0;
		else
			for (int s = 0; s < NSTG; s++)
				grp_q[s] <= src_on[s] ? ctrl_q[s][CTRL_ALT_LSB +: 2] : ctrl_q[s][CTRL_GRP_LSB +: 2];
	end

	// a clear arriving with a new event still counts the event
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			for (int s = 0; s < NSTG; s++)
			begin
				start_cnt_q[s] <= 16'h0000;
				trip_cnt_q[s] <= 16'h0000;
			end
		else
			for (int s = 0; s < NSTG; s++)
			begin
				start_cnt_q[s] <= (cnt_clr[s] ? 16'h0000 : start_cnt_q[s]) + 16'(sp_w[s]);
				trip_cnt_q[s] <= (cnt_clr[s] ? 16'h0000 : trip_cnt_q[s]) + 16'(tp_w[s]);
			end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			ms_cnt_q <= 18'h00000;
			ms_tick_q <= 1'b0;
		end
		else
		begin
			ms_tick_q <= ms_cnt_q == 18'(MS_CYCLES - 1);
			ms_cnt_q <= (ms_cnt_q == 18'(MS_CYCLES - 1)) ? 18'h00000 : ms_cnt_q + 18'h00001;
		end
	end

	// force flag is shared by all stages; a forgotten test mode times out
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			force_q <= 1'b0;
			force_cnt_q <= 20'h00000;
		end
		else if (wr_fire && widx == REG_FORCE && avs_byteenable_in[0])
		begin
			force_q <= avs_writedata_in[0];
			force_cnt_q <= 20'h00000;
		end
		else if (force_q && ms_tick_q)
		begin
			if (force_cnt_q == 20'(FORCE_MS - 1))
				force_q <= 1'b0;
			force_cnt_q <= force_cnt_q + 20'h00001;
		end
	end

	// status bits: stage starts low, trips high; set wins over clear
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			irq_stat_q <= '0;
			irq_en_q <= '0;
			irq_out <= 1'b0;
		end
		else
		begin
			irq_stat_q <= (irq_stat_q & ~((wr_fire && widx == REG_IRQ_CLR) ? avs_writedata_in[2*NSTG-1:0] : '0))
				| {tp_w, sp_w};
			if (wr_fire && widx == REG_IRQ_EN)
				irq_en_q <= avs_writedata_in[2*NSTG-1:0];
			irq_out <= |(irq_stat_q & irq_en_q);
		end
	end

	for (genvar s = 0; s < NSTG; s++)
	begin : g_stg
		logic [6:0]  base;
		prs_set_t    cfg;
		assign base = {3'(s), grp_q[s], 2'b00};
		assign cfg.pickup = set_mem_q[base][15:0];
		assign cfg.no_compare_floor = set_mem_q[base][F_NO_COMPARE_FLOOR_LSB +: 16];
		assign cfg.delay_ms = set_mem_q[base + 7'h01][15:0];
		assign cfg.hyst = set_mem_q[base + 7'h01][F_HYST_LSB +: 7];
		assign cfg.mode = prs_mode_t'(set_mem_q[base + 7'h01][F_MODE_LSB +: 2]);
		assign cfg.sel_a = set_mem_q[base + 7'h02][5:0];
		assign cfg.sel_b = set_mem_q[base + 7'h02][F_SELB_LSB +: 6];

		prs_stage u_stage
		(
			.clk_in          (clk_in),
			.sys_rst_in      (sys_rst_in),
			.ms_tick_in      (ms_tick_q),
			.enable_in       (ctrl_q[s][CTRL_EN_BIT]),
			.period_in       (ctrl_q[s][CTRL_PER_LSB +: 2]),
			.force_on_in     (force_q),
			.force_start_in  (ctrl_q[s][CTRL_FS_BIT]),
			.force_trip_in   (ctrl_q[s][CTRL_FT_BIT]),
			.cfg_in          (cfg),
			.val_a_in        (meas_in[cfg.sel_a]),
			.val_b_in        (meas_in[cfg.sel_b]),
			.status_out      (stat_w[s]),
			.start_pulse_out (sp_w[s]),
			.trip_pulse_out  (tp_w[s])
		);
		assign stage_start_out[s] = stat_w[s].start;
		assign stage_trip_out[s] = stat_w[s].trip;
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	bus_answer_a: assert property (req && wait_q |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
		else $error("bus answer not after one wait state");
	force_timeout_a: assert property (force_q && ms_tick_q && force_cnt_q == 20'(FORCE_MS - 1)
		&& !(wr_fire && widx == REG_FORCE) |=> !force_q)
		else $error("force flag did not time out");
	count_start_a: assert property (sp_w[0] && !cnt_clr[0]
		|=> start_cnt_q[0] == $past(start_cnt_q[0]) + 16'h0001)
		else $error("start counter missed a start");
	count_clear_a: assert property (cnt_clr[0] && !sp_w[0] && !tp_w[0]
		|=> start_cnt_q[0] == 16'h0000 && trip_cnt_q[0] == 16'h0000)
		else $error("counters not cleared");
	irq_level_a: assert property (|(irq_stat_q & irq_en_q) |=> irq_out)
		else $error("enabled status bit without interrupt");
	group_manual_a: assert property (ctrl_q[0][CTRL_SRC_LSB +: 2] == SRC_NONE
		|=> grp_q[0] == $past(ctrl_q[0][CTRL_GRP_LSB +: 2]))
		else $error("manual group not applied");
	group_alt_a: assert property (src_on[6] |=> grp_q[6] == $past(ctrl_q[6][CTRL_ALT_LSB +: 2]))
		else $error("alternate group not applied");
	count_trip_a: assert property (tp_w[0] && !cnt_clr[0]
		|=> trip_cnt_q[0] == $past(trip_cnt_q[0]) + 16'h0001)
		else $error("trip counter missed a trip");
	irq_set_wins_a: assert property (sp_w[0] |=> irq_stat_q[0])
		else $error("start event lost in interrupt status");
endmodule
`default_nettype wire

// ===== prs_meas_model.sv
`timescale 1ns/1ps
`default_nettype none
module prs_meas_model
(
	// clock and reset
	input  wire logic                              clk_in,
	input  wire logic                              sys_rst_in,
	// sample updates from the bench
	input  wire logic                              set_we_in,
	input  wire logic [5:0]                        set_idx_in,
	input  wire logic [15:0]                       set_val_in,
	// output matrix side
	input  wire logic [prs_pkg::NSTG-1:0]          trip_in,
	output var logic [prs_pkg::NSIG-1:0][15:0]     meas_out,
	output var logic [7:0]                         trip_cnt_out
);
	import prs_pkg::*;
	logic trip_q;

	// one sample slot per selector index; 59..63 carry the virtual analog inputs
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			meas_out <= '0;
		else if (set_we_in)
			meas_out[set_idx_in] <= set_val_in;
	end

	// the matrix only sees levels, so a stage 0 trip is counted on its rising edge
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			trip_q       <= 1'b0;
			trip_cnt_out <= 8'h00;
		end
		else
		begin
			trip_q <= trip_in[0];
			if (trip_in[0] && !trip_q)
				trip_cnt_out <= trip_cnt_out + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ===== prs_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module prs_top_tb_top;
	import prs_pkg::*;
	typedef struct packed {logic [31:0] d; logic [31:0] m;} prs_exp_t;
	logic                      clk_in = 1'b0;
	logic                      sys_rst_in = 1'b1;
	logic [11:0]               avs_address = 12'h000;
	logic                      avs_read = 1'b0;
	logic                      avs_write = 1'b0;
	logic [31:0]               avs_wdata = 32'h0000_0000;
	logic [31:0]               avs_rdata;
	logic                      avs_wait;
	logic [15:0]               di = 16'h0000;
	logic [15:0]               vi = 16'h0000;
	logic [15:0]               ind = 16'h0000;
	logic                      mset_we = 1'b0;
	logic [5:0]                mset_idx = 6'h00;
	logic [15:0]               mset_val = 16'h0000;
	logic [NSIG-1:0][15:0]     meas;
	logic [NSTG-1:0]           start_o;
	logic [NSTG-1:0]           trip_o;
	logic                      irq;
	logic [7:0]                trip_cnt;
	logic [31:0]               seed = 32'hC894CCF4;
	int                        error_cnt = 0;
	int                        samples_checked = 0;
	prs_exp_t                  exp_q[$];
	prs_exp_t                  e;

	always #2 clk_in = ~clk_in;

	prs_top #(.MS_CYCLES(10), .FORCE_MS(3)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
		.avs_writedata_in(avs_wdata), .avs_byteenable_in(4'hF), .avs_readdata_out(avs_rdata),
		.avs_waitrequest_out(avs_wait), .meas_in(meas), .digital_input_n_in(di),
		.virtual_input_n_in(vi), .indicator_signal_n_in(ind), .stage_start_out(start_o),
		.stage_trip_out(trip_o), .irq_out(irq));

	prs_meas_model partner (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .set_we_in(mset_we),
		.set_idx_in(mset_idx), .set_val_in(mset_val), .trip_in(trip_o), .meas_out(meas),
		.trip_cnt_out(trip_cnt));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic [9:0] sidx(input int s, input int g, input int w);
		return 10'(s * 16 + g * 4 + w);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		samples_checked++;
		if (seen !== expv)
		begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic final_report();
		if (error_cnt == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// request held until the edge that samples waitrequest low
	task automatic bus(input logic wr, input logic [9:0] ix, input logic [31:0] d);
		@(posedge clk_in);
		avs_address <= {ix, 2'b00};
		avs_write   <= wr;
		avs_read    <= ~wr;
		avs_wdata   <= d;
		do @(posedge clk_in); while (avs_wait !== 1'b0);
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] ix, input logic [31:0] d);
		bus(1'b1, ix, d);
	endtask

	task automatic rd(input logic [9:0] ix, input logic [31:0] d, input logic [31:0] m);
		exp_q.push_back('{d: d, m: m});
		bus(1'b0, ix, 32'h0000_0000);
	endtask

	task automatic setm(input logic [5:0] ix, input logic [15:0] v);
		@(posedge clk_in);
		mset_we  <= 1'b1;
		mset_idx <= ix;
		mset_val <= v;
		@(posedge clk_in);
		mset_we <= 1'b0;
	endtask

	task automatic cfg(input int s, input int g, input logic [15:0] pu, input logic [15:0] fl,
		input logic [15:0] dl, input logic [6:0] hy, input logic [1:0] md, input logic [5:0] a,
		input logic [5:0] b);
		wr(sidx(s, g, 0), {fl, pu});
		wr(sidx(s, g, 1), {6'h00, md, 1'h0, hy, dl});
		wr(sidx(s, g, 2), {18'h00000, b, 2'h0, a});
	endtask

	// read results are compared here, in issue order
	always @(posedge clk_in)
	begin
		if (avs_read === 1'b1 && avs_wait === 1'b0)
		begin
			e = exp_q.pop_front();
			chk(avs_rdata & e.m, e.d & e.m);
		end
	end

	initial
	begin
		repeat (30000) @(posedge clk_in);
		error_cnt++;
		final_report();
	end

	initial
	begin
		repeat (6) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		for (int i = 0; i < NSIG; i++)
		begin
			seed = xs(seed);
			setm(6'(i), seed[15:0]);
		end
		seed = xs(seed);
		di  <= seed[15:0] | 16'h0008;
		vi  <= seed[31:16] | 16'h0008;
		ind <= seed[23:8] | 16'h0008;
		for (int s = 0; s < NSTG; s++)
		begin
			rd(REG_STAT_BASE + 10'(s), 32'h0000_0004, 32'hFFFF_FFFF);
			rd(REG_CNT_BASE + 10'(s), 32'h0000_0000, 32'hFFFF_FFFF);
		end
		wr(10'h120, 32'hFFFF_FFFF);
		rd(10'h120, 32'h0000_0000, 32'hFFFF_FFFF);
		// over mode with a 30 ms delay: start first, trip later
		seed = xs(seed);
		setm(6'h05, 16'h006E + {10'h000, seed[5:0]});
		cfg(0, 0, 16'h0064, 16'h0000, 16'h001E, 7'h0A, CMP_OVER, 6'h05, 6'h00);
		wr(REG_CTRL_BASE, 32'h0000_0001);
		repeat (150) @(posedge clk_in);
		rd(REG_STAT_BASE, 32'h0000_0002, 32'h0000_0007);
		chk({31'h0, start_o[0]}, 32'h0000_0001);
		repeat (300) @(posedge clk_in);
		rd(REG_STAT_BASE, 32'h0000_0003, 32'h0000_0007);
		chk({31'h0, trip_o[0]}, 32'h0000_0001);
		setm(6'h05, 16'h005F);
		repeat (250) @(posedge clk_in);
		rd(REG_STAT_BASE, 32'h0000_0003, 32'h0000_0007);
		setm(6'h05, 16'h0050);
		repeat (250) @(posedge clk_in);
		rd(REG_STAT_BASE, 32'h0000_0000, 32'h0000_0007);
		chk({31'h0, start_o[0]}, 32'h0000_0000);
		rd(REG_CNT_BASE, 32'h0001_0001, 32'hFFFF_FFFF);
		chk({24'h0, trip_cnt}, 32'h0000_0001);
		rd(REG_IRQ_STAT, 32'h0000_0101, 32'h0000_0101);
		wr(REG_IRQ_EN, 32'h0000_0001);
		repeat (2) @(posedge clk_in);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(REG_IRQ_CLR, 32'h0000_0101);
		repeat (2) @(posedge clk_in);
		chk({31'h0, irq}, 32'h0000_0000);
		rd(REG_IRQ_STAT, 32'h0000_0000, 32'h0000_0101);
		wr(REG_CNT_BASE, 32'h0000_0000);
		rd(REG_CNT_BASE, 32'h0000_0000, 32'hFFFF_FFFF);
		// all four modes on one operand pair taken from virtual analog inputs
		setm(6'h3B, 16'h0032);
		setm(6'h3C, 16'h00C8);
		for (int m = 0; m < 4; m++)
		begin
			cfg(m + 1, 0, 16'h0064, 16'h0000, 16'hFFFF, 7'h00, 2'(m), SIG_VAI_BASE, 6'h3C);
			wr(REG_CTRL_BASE + 10'(m + 1), 32'h0000_0001);
		end
		repeat (250) @(posedge clk_in);
		for (int m = 0; m < 4; m++)
			rd(REG_STAT_BASE + 10'(m + 1), (m % 2) ? 32'h2 : 32'h0, 32'h0000_0002);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(sidx(2, 0, 0), 32'h003C_0064);
		repeat (250) @(posedge clk_in);
		rd(REG_STAT_BASE + 10'h002, 32'h0000_0000, 32'h0000_0002);
		// forcing only lasts while the common flag lives
		wr(sidx(5, 0, 0), 32'h0000_7FFF);
		wr(REG_CTRL_BASE + 10'h005, 32'h0003_0005);
		repeat (4) @(posedge clk_in);
		rd(REG_STAT_BASE + 10'h005, 32'h0000_0000, 32'h0000_0007);
		wr(REG_FORCE, 32'h0000_0001);
		repeat (2) @(posedge clk_in);
		rd(REG_STAT_BASE + 10'h005, 32'h0000_0003, 32'h0000_0007);
		repeat (60) @(posedge clk_in);
		rd(REG_FORCE, 32'h0000_0000, 32'h0000_0001);
		rd(REG_STAT_BASE + 10'h005, 32'h0000_0000, 32'h0000_0007);
		// group 2 always starts, group 0 never; bit 3 of every source is high
		setm(6'h07, 16'h0032);
		cfg(6, 0, 16'h7D00, 16'h0000, 16'hFFFF, 7'h00, CMP_OVER, 6'h07, 6'h00);
		cfg(6, 2, 16'hFC18, 16'h0000, 16'hFFFF, 7'h00, CMP_OVER, 6'h07, 6'h00);
		for (int src = 0; src < 4; src++)
		begin
			wr(REG_CTRL_BASE + 10'h006, 32'h0000_3083 | (32'(src) << 8));
			repeat (450) @(posedge clk_in);
			rd(REG_STAT_BASE + 10'h006, src ? 32'h22 : 32'h0, 32'h0000_0032);
		end
		di  <= di & 16'hFFF7;
		vi  <= vi & 16'hFFF7;
		ind <= ind & 16'hFFF7;
		repeat (450) @(posedge clk_in);
		rd(REG_STAT_BASE + 10'h006, 32'h0000_0000, 32'h0000_0032);
		repeat (4) @(posedge clk_in);
		final_report();
	end
endmodule
`default_nettype wire
